// ### src/trt_defs.vh
`ifndef TRT_DEFS_VH
`define TRT_DEFS_VH

// clock and tick timing
`define TRT_CLK_KHZ 25000
`define TRT_TICK_US 100
`define TRT_TICK_DIV_RST (`TRT_TICK_US * `TRT_CLK_KHZ / 1000 - 1)

// block shape
`define TRT_NUM_TIMERS 3
`define TRT_CNT_W 32
`define TRT_DIV_W 16
`define TRT_ADDR_W 8

// register byte offsets
`define TRT_TICK_DIV_OFS 8'h00
`define TRT_IRQ_STAT_OFS 8'h04
`define TRT_IRQ_CLR_OFS 8'h08
`define TRT_IRQ_ENA_OFS 8'h0c
`define TRT_TMR_BASE 8'h10
`define TRT_TMR_STRIDE 8'h10
`define TRT_CTRL_OFS 8'h00
`define TRT_VALUE_OFS 8'h04
`define TRT_RELOAD_OFS 8'h08

// control field positions
`define TRT_CTRL_RUN 0
`define TRT_CTRL_SINGLE 1
`define TRT_CTRL_FORCE 2

// reset values
`define TRT_CNT_RST 32'h0000_0000
`define TRT_RELOAD_RST 32'h0000_0000
`define TRT_IRQ_RST 3'h0

`endif

// ### src/trt_prescaler.v
`timescale 1ns/1ps
`default_nettype none

// shared tick divider: one tick_r pulse every div_val+1 clocks
module trt_prescaler #(
    parameter DIV_W = 16
) (
    input wire clk_sys,
    input wire rst,
    input wire [DIV_W-1:0] div_val,
    output reg tick_r
);

reg [DIV_W-1:0] cnt_r;

// a new divider value is picked up at the next wrap, so a running
// period is never cut short by a rewrite
always @(posedge clk_sys) begin
    if (rst) begin
        cnt_r <= {DIV_W{1'b0}};
        tick_r <= 1'b0;
    end else if (cnt_r == {DIV_W{1'b0}}) begin
        cnt_r <= div_val;
        tick_r <= 1'b1;
    end else begin
        cnt_r <= cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
        tick_r <= 1'b0;
    end
end

endmodule // trt_prescaler

`default_nettype wire

// ### src/trt_timer.v
//Contract
// - There are three independent timers, each with a 32-bit down count.
// - All timers advance on ticks of one shared programmable prescaler.
// - After reset the prescaler gives one tick every 100 us.
// - The divider exists once; control, count and reload exist per timer.
// - Software can read and overwrite each count at any time, even running.
// - A running timer decrements by one per tick from its current count.
// - A tick on a running timer at zero raises its interrupt and reloads.
// - Each timer interrupt is delivered to the interrupt controller.
// - With single-fire set a timer clears its run enable after one interrupt.
// - With single-fire clear a timer wraps repeatedly until disabled.
// - Load-now written together with run enable copies reload into count.
// - A reload value of N gives an interrupt every N plus one ticks.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "trt_defs.vh"

module trt_timer #(
    parameter NUM_TIMERS = `TRT_NUM_TIMERS,
    parameter CNT_W = `TRT_CNT_W,
    parameter DIV_W = `TRT_DIV_W,
    parameter ADDR_W = `TRT_ADDR_W
) (
    input wire clk_sys,
    input wire rst,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [NUM_TIMERS-1:0] timer_irq,
    output reg irq
);

////////////////////////////////////////////////////////////////////////

localparam [31:0] TICK_DIV_FULL = `TRT_TICK_DIV_RST;

// true when addr selects field fofs of timer idx
function tmr_hit;
    input [ADDR_W-1:0] addr;
    input integer idx;
    input [7:0] fofs;
    reg [31:0] want;
    begin
        want = `TRT_TMR_BASE + idx * `TRT_TMR_STRIDE + fofs;
        tmr_hit = (addr == want[ADDR_W-1:0]);
    end
endfunction

// true when addr selects one of the shared registers at ofs
function glb_hit;
    input [ADDR_W-1:0] addr;
    input [7:0] ofs;
    begin
        glb_hit = (addr == ofs[ADDR_W-1:0]);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// apb slave: pready is raised for the first access cycle, so every
// transfer completes with zero wait states

wire setup_ph;
wire wr_en;

assign setup_ph = psel && !penable;
assign wr_en = psel && penable && pready && pwrite;

reg [31:0] rd_nxt;
reg err_nxt;

reg [DIV_W-1:0] div_r;
reg [NUM_TIMERS-1:0] stat_r;
reg [NUM_TIMERS-1:0] ena_r;

wire [NUM_TIMERS*CNT_W-1:0] count_all;
wire [NUM_TIMERS*CNT_W-1:0] reload_all;
wire [NUM_TIMERS-1:0] run_all;
wire [NUM_TIMERS-1:0] single_all;
wire [NUM_TIMERS-1:0] wrap_all;
wire tick;

integer ri;

always @* begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b1;
    if (glb_hit(paddr, `TRT_TICK_DIV_OFS)) begin
        rd_nxt[DIV_W-1:0] = div_r;
        err_nxt = 1'b0;
    end else if (glb_hit(paddr, `TRT_IRQ_STAT_OFS)) begin
        rd_nxt[NUM_TIMERS-1:0] = stat_r;
        err_nxt = pwrite;
    end else if (glb_hit(paddr, `TRT_IRQ_CLR_OFS)) begin
        err_nxt = !pwrite;
    end else if (glb_hit(paddr, `TRT_IRQ_ENA_OFS)) begin
        rd_nxt[NUM_TIMERS-1:0] = ena_r;
        err_nxt = 1'b0;
    end else begin
        for (ri = 0; ri < NUM_TIMERS; ri = ri + 1) begin
            if (tmr_hit(paddr, ri, `TRT_CTRL_OFS)) begin
                // load-now is an action bit and always reads zero
                rd_nxt[`TRT_CTRL_RUN] = run_all[ri];
                rd_nxt[`TRT_CTRL_SINGLE] = single_all[ri];
                err_nxt = 1'b0;
            end
            if (tmr_hit(paddr, ri, `TRT_VALUE_OFS)) begin
                rd_nxt = count_all[ri*CNT_W +: CNT_W];
                err_nxt = 1'b0;
            end
            if (tmr_hit(paddr, ri, `TRT_RELOAD_OFS)) begin
                rd_nxt = reload_all[ri*CNT_W +: CNT_W];
                err_nxt = 1'b0;
            end
        end
    end
end

// read data is captured in the setup cycle; a count read thus shows
// the value one clock before the completing edge
always @(posedge clk_sys) begin
    if (rst) begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end else if (setup_ph) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr <= err_nxt;
    end else begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// shared divider register and prescaler

wire wr_div;

assign wr_div = wr_en && glb_hit(paddr, `TRT_TICK_DIV_OFS);

always @(posedge clk_sys) begin
    if (rst) begin
        div_r <= TICK_DIV_FULL[DIV_W-1:0];
    end else if (wr_div) begin
        div_r <= pwdata[DIV_W-1:0];
    end
end

trt_prescaler #(
    .DIV_W(DIV_W)
) u_presc (
    .clk_sys(clk_sys),
    .rst(rst),
    .div_val(div_r),
    .tick_r(tick)
);

////////////////////////////////////////////////////////////////////////
// per-timer state

genvar gi;

generate
    for (gi = 0; gi < NUM_TIMERS; gi = gi + 1) begin : g_tmr
        reg [CNT_W-1:0] count_r;
        reg [CNT_W-1:0] reload_r;
        reg run_r;
        reg single_r;
        wire wr_ctrl;
        wire wr_value;
        wire wr_reload;
        wire at_zero;
        wire wrap;
        wire start_load;

        assign wr_ctrl = wr_en && tmr_hit(paddr, gi, `TRT_CTRL_OFS);
        assign wr_value = wr_en && tmr_hit(paddr, gi, `TRT_VALUE_OFS);
        assign wr_reload = wr_en && tmr_hit(paddr, gi, `TRT_RELOAD_OFS);
        assign at_zero = (count_r == {CNT_W{1'b0}});
        // a count write on the same edge suppresses the wrap as well
        assign wrap = tick && run_r && at_zero && !wr_value;
        assign start_load = wr_ctrl && pwdata[`TRT_CTRL_RUN]
            && pwdata[`TRT_CTRL_FORCE];

        always @(posedge clk_sys) begin
            if (rst) begin
                reload_r <= `TRT_RELOAD_RST;
            end else if (wr_reload) begin
                reload_r <= pwdata[CNT_W-1:0];
            end
        end

        // software control writes win over the self-disable
        always @(posedge clk_sys) begin
            if (rst) begin
                run_r <= 1'b0;
                single_r <= 1'b0;
            end else if (wr_ctrl) begin
                run_r <= pwdata[`TRT_CTRL_RUN];
                single_r <= pwdata[`TRT_CTRL_SINGLE];
            end else if (wrap && single_r) begin
                run_r <= 1'b0;
            end
        end

        always @(posedge clk_sys) begin
            if (rst) begin
                count_r <= `TRT_CNT_RST;
            end else if (wr_value) begin
                count_r <= pwdata[CNT_W-1:0];
            end else if (start_load) begin
                count_r <= reload_r;
            end else if (wrap) begin
                count_r <= reload_r;
            end else if (tick && run_r) begin
                count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end

        assign count_all[gi*CNT_W +: CNT_W] = count_r;
        assign reload_all[gi*CNT_W +: CNT_W] = reload_r;
        assign run_all[gi] = run_r;
        assign single_all[gi] = single_r;
        assign wrap_all[gi] = wrap;
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// interrupt lines and sticky status

wire wr_clr;
wire wr_ena;

assign wr_clr = wr_en && glb_hit(paddr, `TRT_IRQ_CLR_OFS);
assign wr_ena = wr_en && glb_hit(paddr, `TRT_IRQ_ENA_OFS);

// pulses go out unmasked so the interrupt controller sees every wrap
always @(posedge clk_sys) begin
    if (rst) begin
        timer_irq <= `TRT_IRQ_RST;
    end else begin
        timer_irq <= wrap_all;
    end
end

// a wrap in the clearing cycle keeps its bit set
always @(posedge clk_sys) begin
    if (rst) begin
        stat_r <= `TRT_IRQ_RST;
    end else if (wr_clr) begin
        stat_r <= (stat_r & ~pwdata[NUM_TIMERS-1:0]) | wrap_all;
    end else begin
        stat_r <= stat_r | wrap_all;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        ena_r <= `TRT_IRQ_RST;
    end else if (wr_ena) begin
        ena_r <= pwdata[NUM_TIMERS-1:0];
    end
end

// level output lags the status bits by one clock
always @(posedge clk_sys) begin
    if (rst) begin
        irq <= 1'b0;
    end else begin
        irq <= |(stat_r & ena_r);
    end
end

endmodule // trt_timer

`default_nettype wire

// ### sim/trt_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module trt_timer_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] timer_irq,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_setup_answer: assert property (s_setup ##1 s_access |-> pready)
        else $error("no ready in first access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    a_wrap_pulse: assert property (timer_irq != 3'h0 |=> (timer_irq & $past(timer_irq)) == 3'h0)
        else $error("timer interrupt longer than one cycle");
    // irq trails the status register by one clock, so the cause sits one or two edges back
    a_irq_rise: assert property ($rose(irq) |-> $past(timer_irq) != 3'h0 || $past(pready && pwrite, 2))
        else $error("irq rose without wrap or write");
    a_irq_fall: assert property ($fell(irq) |-> $past(pready && pwrite, 2))
        else $error("irq fell without a write");
    a_err_unmapped: assert property (pready && paddr == 8'h40 |-> pslverr)
        else $error("unmapped access not refused");
    a_value_ok: assert property (pready && paddr == 8'h14 |-> !pslverr)
        else $error("count access refused");
endmodule // trt_timer_sva
bind trt_timer trt_timer_sva u_sva (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_irq(timer_irq), .irq(irq));
`default_nettype wire

// ### sim/trt_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module trt_timer_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [2:0] timer_irq;
    wire irq;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int lst = 0;
    int per = 0;
    int np [3] = '{0, 0, 0};
    logic [31:0] q;
    logic e;
    always #20 clk_sys = ~clk_sys;
    trt_timer uut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_irq(timer_irq), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // wrap counters and timer 0 period, in clocks
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 3; i++) begin
            if (timer_irq[i] === 1'b1) np[i] <= np[i] + 1;
        end
        if (timer_irq[0] === 1'b1) begin
            per <= cyc - lst;
            lst <= cyc;
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        tests_run++;
        if (g !== ex) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wait_wrap(input int i, input int k);
        while (np[i] < k) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h00);
        chk("tick divider", 32'h0000_09c3, q);
        rd(8'h14);
        chk("count 0", 32'h0, q);
    endtask
    task automatic t_periodic;
        wr(8'h00, 32'h3);
        wr(8'h18, 32'h9);
        wr(8'h10, 32'h5);
        wait_wrap(0, 3);
        chk("wrap period", 32'd40, per[31:0]);
        chk("masked irq", 32'h0, {31'h0, irq});
    endtask
    task automatic t_single;
        wr(8'h28, 32'h2);
        wr(8'h20, 32'h7);
        // load-now put the reload in; at most one tick lands before the read, no wrap
        rd(8'h24);
        chk("forced count", 32'h1, {31'h0, (q == 2 || q == 1) && np[1] == 0});
        repeat (200) @(posedge clk_sys);
        chk("single fire wraps", 32'd1, np[1]);
        rd(8'h24);
        chk("stopped count", 32'h2, q);
    endtask
    task automatic t_count;
        wr(8'h34, 32'd1000);
        wr(8'h30, 32'h1);
        repeat (40) @(posedge clk_sys);
        rd(8'h34);
        chk("running count", 32'h1, {31'h0, q >= 988 && q <= 991});
        // overwrite while running; a tick may land before the read
        wr(8'h34, 32'h5);
        rd(8'h34);
        chk("rewritten count", 32'h1, {31'h0, q == 5 || q == 4});
        wait_wrap(2, 1);
        chk("timer 2 wrap", 32'd1, np[2]);
    endtask
    task automatic t_irq;
        wr(8'h10, 32'h0);
        wr(8'h30, 32'h0);
        rd(8'h04);
        chk("status", 32'h7, q);
        wr(8'h0c, 32'h7);
        repeat (2) @(posedge clk_sys);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h7);
        repeat (2) @(posedge clk_sys);
        chk("irq off", 32'h0, {31'h0, irq});
        rd(8'h04);
        chk("status cleared", 32'h0, q);
        apb(1'b0, 8'h40, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask
    task automatic results;
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        fail_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_periodic();
        t_single();
        t_count();
        t_irq();
        results();
    end
endmodule // trt_timer_tb_top
`default_nettype wire
